/* hdl/smpsc_osc.sv */
// Switching oscillator with triangular frequency jitter and duty cap.
`timescale 1ns/1ns
`include "smpsc_consts.svh"
module smpsc_osc #(
  parameter int NOM_CYC     = `SMPSC_OSC_CYC,
  parameter int JIT_CYC     = `SMPSC_JIT_CYC,
  parameter int JIT_PER_CYC = `SMPSC_JIT_PER_CYC
) (
  // Clock and reset.
  input  wire logic  ref_clk,
  input  wire logic  nrst,
  // Cycle pulses and jitter enable.
  smpsc_ctl_if.oscm  ctl
);
  import smpsc_pkg::*;

  // One offset step per quarter of the jitter period divided by the swing.
  localparam int JSTEP = (JIT_PER_CYC / (4 * JIT_CYC)) > 0 ? JIT_PER_CYC / (4 * JIT_CYC) : 1;
  localparam int JW    = $clog2(JSTEP + 1);

  typedef struct packed {
    logic [11:0]   cnt;
    logic [11:0]   off;
    logic          dn;
    logic [JW-1:0] jt;
    logic          start;
    logic          dend;
  } smpsc_osc_st_t;

  smpsc_osc_st_t r_q;
  smpsc_osc_st_t r_d;
  logic [11:0]   per;
  logic [11:0]   on_lim;

  // Period swings from NOM-J to NOM+J; a fixed offset of J when jitter is off.
  always_comb begin
    per    = 12'(NOM_CYC - JIT_CYC) + r_q.off;
    on_lim = 12'((per * 12'h003) >> 2);
  end

  // Cycle counter, jitter sweep and the two pulses.
  always_comb begin
    r_d       = r_q;
    r_d.start = 1'b0;
    r_d.dend  = 1'b0;
    if (r_q.cnt >= per - 12'h001) begin
      r_d.cnt   = '0;
      r_d.start = 1'b1;
    end else begin
      r_d.cnt = r_q.cnt + 12'h001;
    end
    // A window, not an equality: while jitter runs the cap can slide down past the count.
    if ((r_q.cnt + 12'h001 >= on_lim) && (r_q.cnt < per - 12'h001)) begin
      r_d.dend = 1'b1;
    end
    if (!ctl.jitter_en) begin
      r_d.off = 12'(JIT_CYC);
      r_d.jt  = '0;
      r_d.dn  = 1'b0;
    end else if (r_q.jt >= JW'(JSTEP - 1)) begin
      r_d.jt = '0;
      if (r_q.dn) begin
        r_d.off = r_q.off - 12'h001;
        r_d.dn  = (r_q.off > 12'h001);
      end else begin
        r_d.off = r_q.off + 12'h001;
        r_d.dn  = (r_q.off + 12'h001 >= 12'(2 * JIT_CYC));
      end
    end else begin
      r_d.jt = r_q.jt + JW'(1);
    end
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_q     <= '0;
      r_q.off <= 12'(JIT_CYC);
    end else begin
      r_q <= r_d;
    end
  end

  assign ctl.cyc_start = r_q.start;
  assign ctl.duty_end  = r_q.dend;

  // Duty end never meets a cycle start and never comes before the shortest cap.
  property p_dend_pos;
    @(posedge ref_clk) disable iff (!nrst)
    r_q.dend |-> !r_q.start && r_q.cnt >= 12'(((NOM_CYC - JIT_CYC) * 3) / 4);
  endproperty
  a_dend_pos: assert property (p_dend_pos)
    else $error("duty end pulse off its cap position");
endmodule

/* hdl/smpsc_sync.sv */
// Two-stage synchronisers for the analog comparator outputs.
`timescale 1ns/1ns
module smpsc_sync (
  // Clock and reset.
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  // Raw comparator levels.
  input  wire smpsc_pkg::smpsc_cmp_t raw,
  // Synchronised levels.
  smpsc_ctl_if.syncm           ctl
);
  import smpsc_pkg::*;

  typedef struct packed {
    smpsc_cmp_t s1;
    smpsc_cmp_t s2;
  } smpsc_sync_st_t;

  smpsc_sync_st_t r_q;
  smpsc_sync_st_t r_d;

  // The first stage feeds only the second; nothing else looks at it.
  always_comb begin
    r_d    = r_q;
    r_d.s1 = raw;
    r_d.s2 = r_q.s1;
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign ctl.cmp = r_q.s2;
endmodule

/* hdl/smpsc_top.sv */
// PWM gate control, soft start sequencer and mode blanking timers.
`timescale 1ns/1ns
`include "smpsc_consts.svh"
module smpsc_top #(
  parameter int SS_STEP_CYC  = `SMPSC_SS_STEP_CYC,
  parameter int SS_TOTAL_CYC = `SMPSC_SS_TOTAL_CYC,
  parameter int BLANK_CYC    = `SMPSC_BLANK_CYC,
  parameter int JIT_PER_CYC  = `SMPSC_JIT_PER_CYC
) (
  // Clock and reset; reset is the undervoltage lockout.
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Supply comparators.
  input  wire logic       vcc_on_cmp,
  input  wire logic       vcc_uvlo_cmp,
  // Current sense and feedback comparators.
  input  wire logic       pwm_cmp,
  input  wire logic       ss_cmp,
  input  wire logic       peak_limit_comparator,
  input  wire logic       burst_limit_comparator,
  input  wire logic       fb_low_cmp,
  input  wire logic       overload_comparator,
  input  wire logic       blanking_level_comparator,
  // Power switch gate.
  output logic            gate_drive,
  // Soft start sink control.
  output logic            ss_sink_on,
  output logic            ss_step,
  output logic [4:0]      softstart_limit_level,
  output logic            ss_done,
  // Mode and blanking pin control.
  output logic            burst_limit_gate,
  output logic            blanking_clamp_switch,
  output logic            restart_mode
);
  import smpsc_pkg::*;

  // ----------------------------------------------------------------
  // Local sizes
  // ----------------------------------------------------------------
  localparam int SSW  = $clog2(SS_TOTAL_CYC + 1);
  localparam int STW  = $clog2(SS_STEP_CYC + 1);
  localparam int BW   = $clog2(BLANK_CYC + 1);
  localparam int SPW  = $clog2(`SMPSC_SPIKE_CYC + 1);
  localparam int MAXON = (`SMPSC_OSC_CYC * 3) / 4;
  localparam int LEBN  = `SMPSC_LEB_CYC;
  localparam int SPKN  = `SMPSC_SPIKE_CYC;

  typedef struct packed {
    smpsc_state_t st;
    logic         latch;
    logic         gate;
    logic [3:0]   leb;
    logic [11:0]  on_cnt;
    logic [SSW-1:0] ss_cnt;
    logic [STW-1:0] step_cnt;
    logic [4:0]   level;
    logic         step;
    logic         done;
    logic [BW-1:0] bcnt;
    logic [BW-1:0] ocnt;
    logic [SPW-1:0] spk;
  } smpsc_top_st_t;

  smpsc_top_st_t r_q;
  smpsc_top_st_t r_d;
  smpsc_ctl_if   ctl ();
  smpsc_cmp_t    raw;

  // ----------------------------------------------------------------
  // Synchroniser and oscillator
  // ----------------------------------------------------------------
  assign raw = {blanking_level_comparator, overload_comparator, fb_low_cmp,
                burst_limit_comparator, peak_limit_comparator, ss_cmp, pwm_cmp,
                vcc_uvlo_cmp, vcc_on_cmp};

  smpsc_sync u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .raw     (raw),
    .ctl     (ctl.syncm)
  );

  smpsc_osc #(
    .JIT_PER_CYC (JIT_PER_CYC)
  ) u_osc (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ctl     (ctl.oscm)
  );

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  logic        c_on;
  logic        c_uvlo;
  logic        c_fb_low;
  logic        c_ovl;
  logic        c_blk;
  logic        run;
  logic        blank;
  logic        cmp_rst;
  logic [11:0] ss_lim;
  logic        ovl_exp;
  logic        rst_gate;

  always_comb begin
    c_on     = ctl.cmp[`SMPSC_C_VCC_ON];
    c_uvlo   = ctl.cmp[`SMPSC_C_UVLO];
    c_fb_low = ctl.cmp[`SMPSC_C_FB_LOW];
    c_ovl    = ctl.cmp[`SMPSC_C_OVL];
    c_blk    = ctl.cmp[`SMPSC_C_BLK_LVL];
    run      = !c_uvlo && (r_q.st == SMPSC_SOFT || r_q.st == SMPSC_NORMAL ||
                           r_q.st == SMPSC_BURST);
    // The setting edge itself is blanked too, since leb is loaded only then.
    blank    = (r_q.leb != 4'h0) || ctl.cyc_start;
    cmp_rst  = !blank && (ctl.cmp[`SMPSC_C_PWM] || ctl.cmp[`SMPSC_C_PEAK] ||
               (ctl.cmp[`SMPSC_C_SS] && r_q.st == SMPSC_SOFT) ||
               (ctl.cmp[`SMPSC_C_BURST] && r_q.st == SMPSC_BURST));
    // Digital duty ceiling that grows with the soft start level.
    ss_lim   = 12'((17'(r_q.level) * 17'(MAXON)) >> 5);
    ovl_exp  = (r_q.ocnt == BW'(BLANK_CYC));
    rst_gate = ovl_exp && c_blk && c_ovl;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d      = r_q;
    r_d.step = 1'b0;

    // PWM latch: set by cycle start, cleared by any enabled reset source.
    if (run && ctl.cyc_start) begin
      r_d.latch  = 1'b1;
      r_d.leb    = 4'(LEBN);
      r_d.on_cnt = '0;
    end else begin
      r_d.leb    = (r_q.leb != 4'h0) ? r_q.leb - 4'h1 : 4'h0;
      r_d.on_cnt = r_q.on_cnt + 12'h001;
    end
    if (cmp_rst || ctl.duty_end || !run) begin
      r_d.latch = 1'b0;
    end
    if (r_q.st == SMPSC_SOFT && r_d.on_cnt >= ss_lim) begin
      r_d.latch = 1'b0;
    end
    r_d.gate = r_d.latch && run;

    // Mode sequencing.
    case (r_q.st)
      SMPSC_OFF: begin
        r_d.ss_cnt   = '0;
        r_d.step_cnt = '0;
        r_d.level    = '0;
        r_d.done     = 1'b0;
        if (c_on && !c_uvlo) begin
          r_d.st = SMPSC_SOFT;
        end
      end
      SMPSC_SOFT: begin
        r_d.ss_cnt = r_q.ss_cnt + SSW'(1);
        if (r_q.step_cnt == STW'(SS_STEP_CYC - 1)) begin
          r_d.step_cnt = '0;
          r_d.step     = 1'b1;
          if (r_q.level != 5'h1f) begin
            r_d.level = r_q.level + 5'h01;
          end
        end else begin
          r_d.step_cnt = r_q.step_cnt + STW'(1);
        end
        if (r_q.ss_cnt == SSW'(SS_TOTAL_CYC - 1)) begin
          r_d.st   = SMPSC_NORMAL;
          r_d.done = 1'b1;
          r_d.level = 5'h1f;
        end
      end
      SMPSC_NORMAL: begin
        if (c_fb_low && r_q.bcnt == BW'(BLANK_CYC - 1)) begin
          r_d.st = SMPSC_BURST;
        end
        if (r_q.spk == SPW'(SPKN - 1) && rst_gate) begin
          r_d.st = SMPSC_RESTART;
        end
      end
      SMPSC_BURST: begin
        if (c_ovl) begin
          r_d.st = SMPSC_NORMAL;
        end
      end
      SMPSC_RESTART: begin
        // Held off until the supply collapses; the next start reruns soft start.
        r_d.st = SMPSC_RESTART;
      end
      default: begin
        r_d.st = SMPSC_OFF;
      end
    endcase

    // Burst entry timer: basic blanking only, cleared whenever feedback rises.
    if (r_q.st == SMPSC_NORMAL && c_fb_low) begin
      r_d.bcnt = r_q.bcnt + BW'(1);
    end else begin
      r_d.bcnt = '0;
    end

    // Overload timer: holds at expiry while the blanking node charges.
    if (r_q.st == SMPSC_NORMAL && c_ovl) begin
      if (!ovl_exp) begin
        r_d.ocnt = r_q.ocnt + BW'(1);
      end
    end else begin
      r_d.ocnt = '0;
    end

    // Spike blanking after the restart gate opens.
    if (rst_gate && r_q.st == SMPSC_NORMAL) begin
      if (r_q.spk != SPW'(SPKN - 1)) begin
        r_d.spk = r_q.spk + SPW'(1);
      end
    end else begin
      r_d.spk = '0;
    end

    // An undervoltage event drops everything back to step zero.
    if (c_uvlo) begin
      r_d.st    = SMPSC_OFF;
      r_d.level = '0;
      r_d.ss_cnt = '0;
      r_d.done  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_q    <= '0;
      r_q.st <= SMPSC_OFF;
    end else begin
      r_q <= r_d;
    end
  end

  assign ctl.jitter_en         = r_q.done;
  assign gate_drive            = r_q.gate;
  assign ss_sink_on            = (r_q.st == SMPSC_SOFT);
  assign ss_step               = r_q.step;
  assign softstart_limit_level = r_q.level;
  assign ss_done               = r_q.done;
  assign burst_limit_gate      = (r_q.st == SMPSC_BURST);
  assign blanking_clamp_switch = !ovl_exp;
  assign restart_mode          = (r_q.st == SMPSC_RESTART);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_uvlo_gate;
    @(posedge ref_clk) disable iff (!nrst)
    c_uvlo |=> !gate_drive ##1 !gate_drive || !c_uvlo;
  endproperty
  a_uvlo_gate: assert property (p_uvlo_gate)
    else $error("gate driven during undervoltage");

  property p_ss_start;
    @(posedge ref_clk) disable iff (!nrst)
    r_q.st == SMPSC_OFF && c_on && !c_uvlo |=> r_q.st == SMPSC_SOFT && r_q.level == 5'h00;
  endproperty
  a_ss_start: assert property (p_ss_start)
    else $error("soft start did not begin");

  property p_ss_step;
    @(posedge ref_clk) disable iff (!nrst)
    r_q.st == SMPSC_SOFT && r_d.step && !c_uvlo && r_q.level != 5'h1f
      |=> ss_step && softstart_limit_level == $past(softstart_limit_level) + 5'h01;
  endproperty
  a_ss_step: assert property (p_ss_step)
    else $error("level did not step with pulse");

  property p_ss_done;
    @(posedge ref_clk) disable iff (!nrst)
    r_q.st == SMPSC_SOFT && r_q.ss_cnt == SSW'(SS_TOTAL_CYC - 1) && !c_uvlo
      |=> ss_done && !ss_sink_on;
  endproperty
  a_ss_done: assert property (p_ss_done)
    else $error("soft start did not finish on time");

  property p_peak_off;
    @(posedge ref_clk) disable iff (!nrst)
    gate_drive && r_q.leb == 4'h0 && ctl.cmp[`SMPSC_C_PEAK] && !ctl.cyc_start
      |=> !gate_drive;
  endproperty
  a_peak_off: assert property (p_peak_off)
    else $error("peak limit did not end pulse");

  property p_leb;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(gate_drive) && r_q.st == SMPSC_NORMAL && !c_uvlo && !ctl.duty_end
      && r_q.on_cnt < 12'(MAXON - 8) |-> ##1 r_q.leb != 4'h0;
  endproperty
  a_leb: assert property (p_leb)
    else $error("blanking not running after turn-on");

  property p_duty_cap;
    @(posedge ref_clk) disable iff (!nrst)
    ctl.duty_end |=> !gate_drive;
  endproperty
  a_duty_cap: assert property (p_duty_cap)
    else $error("gate on past maximum duty");

  property p_burst_entry;
    @(posedge ref_clk) disable iff (!nrst)
    r_q.st == SMPSC_NORMAL && c_fb_low && !c_uvlo && r_q.bcnt == BW'(BLANK_CYC - 1)
      && !(r_q.spk == SPW'(SPKN - 1) && rst_gate) |=> burst_limit_gate;
  endproperty
  a_burst_entry: assert property (p_burst_entry)
    else $error("burst mode not entered at expiry");

  property p_timer_clear;
    @(posedge ref_clk) disable iff (!nrst)
    !c_fb_low |=> r_q.bcnt == '0;
  endproperty
  a_timer_clear: assert property (p_timer_clear)
    else $error("burst timer not cleared");

  property p_clamp;
    @(posedge ref_clk) disable iff (!nrst)
    !blanking_clamp_switch |-> r_q.ocnt == BW'(BLANK_CYC) && $past(c_ovl);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp opened before timer expiry");

  property p_restart;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(restart_mode) |-> $past(r_q.spk) == SPW'(SPKN - 1) && $past(rst_gate);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart without spike blanking");

  c_soft_done: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(ss_done));
  c_burst: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(burst_limit_gate));
  c_restart: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(restart_mode));
  c_peak: cover property (@(posedge ref_clk) disable iff (!nrst)
    gate_drive ##1 !gate_drive && !ctl.duty_end);
endmodule

/* pkg/smpsc_consts.svh */
// Constants of the switching supply PWM and soft start controller.
`ifndef SMPSC_CONSTS_SVH
`define SMPSC_CONSTS_SVH

// Clock rate and timing figures in their own units.
`define SMPSC_CLK_KHZ      25000
`define SMPSC_SS_STEP_US   600
`define SMPSC_SS_TOTAL_MS  20
`define SMPSC_BLANK_MS     20
`define SMPSC_JIT_PER_MS   4
`define SMPSC_LEB_NS       220
`define SMPSC_SPIKE_US     30
`define SMPSC_OSC_KHZ      65
`define SMPSC_JIT_PCT      4
`define SMPSC_SS_STEPS     32

// Derived cycle counts.
`define SMPSC_SS_STEP_CYC  (`SMPSC_SS_STEP_US * `SMPSC_CLK_KHZ / 1000)
`define SMPSC_SS_TOTAL_CYC (`SMPSC_SS_TOTAL_MS * `SMPSC_CLK_KHZ)
`define SMPSC_BLANK_CYC    (`SMPSC_BLANK_MS * `SMPSC_CLK_KHZ)
`define SMPSC_JIT_PER_CYC  (`SMPSC_JIT_PER_MS * `SMPSC_CLK_KHZ)
`define SMPSC_LEB_CYC      ((`SMPSC_LEB_NS * `SMPSC_CLK_KHZ + 999999) / 1000000)
`define SMPSC_SPIKE_CYC    (`SMPSC_SPIKE_US * `SMPSC_CLK_KHZ / 1000)
`define SMPSC_OSC_CYC      (`SMPSC_CLK_KHZ / `SMPSC_OSC_KHZ)
`define SMPSC_JIT_CYC      (`SMPSC_OSC_CYC * `SMPSC_JIT_PCT / 100)

// Comparator bit positions in the synchronised vector.
`define SMPSC_CMP_N        9
`define SMPSC_C_VCC_ON     0
`define SMPSC_C_UVLO       1
`define SMPSC_C_PWM        2
`define SMPSC_C_SS         3
`define SMPSC_C_PEAK       4
`define SMPSC_C_BURST      5
`define SMPSC_C_FB_LOW     6
`define SMPSC_C_OVL        7
`define SMPSC_C_BLK_LVL    8

`endif

/* pkg/smpsc_ctl_if.sv */
// Internal carrier between synchroniser, oscillator and control core.
`timescale 1ns/1ns
interface smpsc_ctl_if;
  import smpsc_pkg::*;
  smpsc_cmp_t cmp;
  logic       cyc_start;
  logic       duty_end;
  logic       jitter_en;

  modport syncm (output cmp);
  modport oscm  (input jitter_en, output cyc_start, output duty_end);
  modport core  (input cmp, input cyc_start, input duty_end, output jitter_en);
endinterface

/* pkg/smpsc_pkg.sv */
// Types shared by the controller modules.
package smpsc_pkg;

  // Operating states, one-hot.
  typedef enum logic [4:0] {
    SMPSC_OFF     = 5'h01,
    SMPSC_SOFT    = 5'h02,
    SMPSC_NORMAL  = 5'h04,
    SMPSC_BURST   = 5'h08,
    SMPSC_RESTART = 5'h10
  } smpsc_state_t;

  typedef logic [8:0] smpsc_cmp_t;

endpackage

/* verif/smps_pwm_softstart_control_tb_top.sv */
// Self-checking bench: soft start, PWM trips, mode blanking timers and restart.
`timescale 1ns/1ns
module smps_pwm_softstart_control_tb_top;
  import smpsc_pkg::*;

  // ----------------------------------------------------------------
  // Shortened timer figures and bench state
  // ----------------------------------------------------------------
  localparam int STEP  = 20;
  localparam int SOFT  = 700;
  localparam int BLNK  = 300;
  localparam int SPIKE = 750;
  localparam int LIMIT = 15000;
  typedef struct { logic [2:0] v; int lo; int hi; } smpsc_note_t;

  logic        ref_clk;
  logic        nrst;
  logic        vcc_on;
  logic        vcc_uvlo;
  logic        fb_low;
  logic        ovl;
  logic        blk_lvl;
  logic        pwm_c;
  logic        ss_c;
  logic        peak_c;
  logic        burst_c;
  logic        gate_drive;
  logic        ss_sink_on;
  logic        ss_step;
  logic [4:0]  lvl;
  logic        ss_done;
  logic        burst_limit_gate;
  logic        blanking_clamp_switch;
  logic        restart_mode;
  logic [8:0]  ton;
  logic [1:0]  sel;
  logic        spike;
  logic [1:0]  cut_exp;
  logic        g_q;
  logic [31:0] rs;
  logic [2:0]  vprev;
  logic        gprev;
  smpsc_note_t q[$];
  int          cyc;
  int          errors;
  int          cmp_count;
  int          glen;
  int          rise;
  int          lstep;
  int          nstep;
  int          pmin;
  int          pmax;

  smpsc_top #(.SS_STEP_CYC(STEP), .SS_TOTAL_CYC(SOFT), .BLANK_CYC(BLNK),
              .JIT_PER_CYC(600)) uut (
    .ref_clk                   (ref_clk),
    .nrst                      (nrst),
    .vcc_on_cmp                (vcc_on),
    .vcc_uvlo_cmp              (vcc_uvlo),
    .pwm_cmp                   (pwm_c),
    .ss_cmp                    (ss_c),
    .peak_limit_comparator     (peak_c),
    .burst_limit_comparator    (burst_c),
    .fb_low_cmp                (fb_low),
    .overload_comparator       (ovl),
    .blanking_level_comparator (blk_lvl),
    .gate_drive                (gate_drive),
    .ss_sink_on                (ss_sink_on),
    .ss_step                   (ss_step),
    .softstart_limit_level     (lvl),
    .ss_done                   (ss_done),
    .burst_limit_gate          (burst_limit_gate),
    .blanking_clamp_switch     (blanking_clamp_switch),
    .restart_mode              (restart_mode)
  );

  smpsc_power_model partner (
    .ref_clk    (ref_clk),
    .gate_drive (gate_drive),
    .ton        (ton),
    .sel        (sel),
    .spike      (spike),
    .pwm_cmp    (pwm_c),
    .ss_cmp     (ss_c),
    .peak_cmp   (peak_c),
    .burst_cmp  (burst_c)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic close_out();
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Mode changes land three edges after the input edge (four counts of cyc): two sync flops, one state edge.
  task automatic note(input logic [2:0] v, input int d);
    smpsc_note_t n;
    n.v  = v;
    n.lo = cyc + d - 3;
    n.hi = cyc + d + 3;
    q.push_back(n);
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Switching sel mid-pulse would blur which comparator ended it.
  task automatic idle_gate();
    while (gate_drive !== 1'b0) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Clock, cycle count, random on-time and hang guard
  // ----------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    g_q <= gate_drive;
    if (gate_drive === 1'b0 && g_q === 1'b1) begin
      rs = xs(rs);
      ton <= 9'(20 + rs % 200);
    end
    if (cyc > LIMIT) begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Output watcher: settled values are sampled on the falling edge
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (nrst) begin
      if ({ss_sink_on, burst_limit_gate, restart_mode} !== vprev) begin
        if (q.size() == 0) begin
          chk("mode", 32'(vprev), 32'({ss_sink_on, burst_limit_gate, restart_mode}));
        end else begin
          chk("mode", 32'(q[0].v), 32'({ss_sink_on, burst_limit_gate, restart_mode}));
          chk("when", 1, cyc >= q[0].lo && cyc <= q[0].hi);
          void'(q.pop_front());
        end
      end
      if (!ss_sink_on && !ss_done) begin
        chk("gate_off", 0, gate_drive);
        rise = -100000;
      end
      if (ss_sink_on && lvl === 5'h00) chk("gate_l0", 0, gate_drive);
      if (ss_step === 1'b1) begin
        if (lstep > 0) chk("step", STEP, cyc - lstep);
        lstep = cyc;
        nstep++;
      end
      if (!ss_sink_on) lstep = 0;
      if (gate_drive === 1'b1) glen++;
      if (gate_drive === 1'b1 && !gprev && cyc - rise < 1000) begin
        if (ss_sink_on) chk("period", 384, cyc - rise);
        if (ss_done && !burst_limit_gate && !restart_mode) begin
          chk("jit", 1, cyc - rise >= 369 && cyc - rise <= 399);
          pmin = (cyc - rise < pmin) ? cyc - rise : pmin;
          pmax = (cyc - rise > pmax) ? cyc - rise : pmax;
        end
      end
      if (gate_drive === 1'b1 && !gprev) rise = cyc;
      if (gate_drive === 1'b0 && gprev) begin
        if (cut_exp == 2'h1) chk("cut", 1, glen >= ton + 2 && glen <= ton + 4);
        // The cap follows the jittered period: 3/4 of 369 up to 3/4 of 399 cycles.
        if (cut_exp == 2'h2) chk("cap", 1, glen >= 276 && glen <= 299);
        if (cut_exp == 2'h3) chk("ss_cut", 1, glen <= ton + 4);
        glen = 0;
      end
    end
    vprev = {ss_sink_on, burst_limit_gate, restart_mode};
    gprev = (gate_drive === 1'b1);
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, vcc_on, vcc_uvlo, fb_low, ovl, blk_lvl, spike, g_q} = 8'h00;
    {sel, cut_exp, vprev, gprev} = 8'h00;
    ton = 9'h064;
    rs = 32'h0000_0023;
    cyc       = 0;
    errors    = 0;
    cmp_count = 0;
    glen      = 0;
    lstep     = 0;
    nstep     = 0;
    pmin      = 1000;
    pmax      = 0;
    rise      = -100000;
    cyc_wait(4);
    nrst <= 1'b1;
    cyc_wait(10);
    vcc_on <= 1'b1;
    note(3'b100, 4);
    note(3'b000, 4 + SOFT);
    cyc_wait(SOFT + 14);
    chk("level", 5'h1f, lvl);
    chk("steps", 1, nstep >= 31);
    chk("done", 1, ss_done);
    // Each comparator in normal mode: pwm and peak cut, soft and burst ignored.
    for (int s = 0; s < 4; s++) begin
      idle_gate();
      sel     <= 2'(s);
      spike   <= 1'b1;
      cut_exp <= (s < 2) ? 2'h1 : 2'h2;
      cyc_wait(1200);
    end
    chk("jitter", 1, pmax > pmin);
    cut_exp <= 2'h0;
    fb_low  <= 1'b1;
    cyc_wait(200);
    fb_low <= 1'b0;
    cyc_wait(20);
    fb_low <= 1'b1;
    note(3'b010, 4 + BLNK);
    cyc_wait(BLNK + 20);
    idle_gate();
    cut_exp <= 2'h1;
    cyc_wait(1200);
    idle_gate();
    cut_exp <= 2'h0;
    fb_low  <= 1'b0;
    ovl     <= 1'b1;
    note(3'b000, 4);
    cyc_wait(BLNK - 20);
    chk("clamp", 1, blanking_clamp_switch);
    cyc_wait(50);
    chk("clamp", 0, blanking_clamp_switch);
    cyc_wait(400);
    blk_lvl <= 1'b1;
    note(3'b001, 4 + SPIKE);
    cyc_wait(SPIKE + 20);
    {vcc_on, vcc_uvlo, ovl, blk_lvl} <= 4'b0100;
    note(3'b000, 4);
    cyc_wait(20);
    chk("done", 0, ss_done);
    chk("level", 5'h00, lvl);
    {vcc_on, vcc_uvlo} <= 2'b10;
    // Second start lets the soft start comparator end pulses; stop judging before normal mode.
    sel     <= 2'h2;
    cut_exp <= 2'h3;
    note(3'b100, 4);
    note(3'b000, 4 + SOFT);
    cyc_wait(8);
    chk("level", 5'h00, lvl);
    cyc_wait(SOFT - 100);
    cut_exp <= 2'h0;
    cyc_wait(120);
    chk("done", 1, ss_done);
    chk("queue", 0, q.size());
    close_out();
  end
endmodule

/* verif/smpsc_power_model.sv */
// Behavioural power switch with its current sense and feedback comparators.
`timescale 1ns/1ns
module smpsc_power_model (
  // Clock and gate.
  input  wire logic       ref_clk,
  input  wire logic       gate_drive,
  // On-time at which the sense ramp trips, comparator choice, edge spike.
  input  wire logic [8:0] ton,
  input  wire logic [1:0] sel,
  input  wire logic       spike,
  // Comparator levels.
  output logic            pwm_cmp,
  output logic            ss_cmp,
  output logic            peak_cmp,
  output logic            burst_cmp
);
  logic [8:0] cnt_q;
  logic       on;
  logic       trip;

  // The sense ramp climbs while the switch conducts and collapses when it opens.
  always @(posedge ref_clk) begin
    if (on) begin
      cnt_q <= cnt_q + 9'h001;
    end else begin
      cnt_q <= 9'h000;
    end
  end

  // The chosen comparator trips at the on-time; the spike mimics turn-on ringing.
  assign on        = (gate_drive === 1'b1);
  assign trip      = on && (cnt_q >= ton);
  assign pwm_cmp   = trip && (sel == 2'h0);
  assign ss_cmp    = trip && (sel == 2'h2);
  assign peak_cmp  = (trip && (sel == 2'h1)) || (spike && on && (cnt_q < 9'h003));
  assign burst_cmp = trip && (sel == 2'h3);
endmodule
